// ===== shared/llsfd_pkg.sv
// shared constants, types and functions of the fabric datapath block
package llsfd_pkg;
  typedef enum logic [1:0] {PATH_STD, PATH_TENG, PATH_HS128} llsfd_path_e;
  typedef enum logic [1:0] {MODE_DUPLEX, MODE_RX, MODE_TX} llsfd_mode_e;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLOCKS = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
  localparam logic [31:0] CTRL_WMASK = 32'h007f_ffff;
  localparam int CTRL_PATH_LSB = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_LANES_LSB = 4;
  localparam int CTRL_BOND_EN = 10;
  localparam int CTRL_BOND_XBANK = 11;
  localparam int CTRL_FAB_LSB = 12;
  localparam int CTRL_PMA_LSB = 16;
  localparam int CTRL_TXCORE = 19;
  localparam int CTRL_RXCORE = 20;
  localparam int CTRL_PLL_LSB = 21;
  localparam int ST_TX_DROP = 6;
  localparam int ST_TX_STARVE = 7;
  localparam int ST_RX_DROP = 8;
  localparam int CK_REF_LSB = 8;
  localparam int CK_PLL_LSB = 16;
  localparam logic [5:0] MAX_LANES = 6'h20;
  localparam logic [5:0] HS_MAX_LANES = 6'h04;
  localparam logic [5:0] BOND_MAX_CH = 6'h06;
  localparam int WORD_W = 128;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL = 4'h8;

  function automatic logic [7:0] fabBits(input logic [3:0] code);
    unique case (code)
      4'h0: return 8'h08;
      4'h1: return 8'h0a;
      4'h2: return 8'h10;
      4'h3: return 8'h14;
      4'h4: return 8'h20;
      4'h5: return 8'h28;
      4'h6: return 8'h32;
      4'h7: return 8'h40;
      4'h8: return 8'h42;
      4'h9: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction : fabBits

  function automatic logic [7:0] pmaBits(input logic [2:0] code);
    unique case (code)
      3'h0: return 8'h08;
      3'h1: return 8'h0a;
      3'h2: return 8'h10;
      3'h3: return 8'h14;
      3'h4: return 8'h20;
      3'h5: return 8'h28;
      3'h6: return 8'h40;
      default: return 8'h00;
    endcase
  endfunction : pmaBits

  // legal fabric to pcs-pma width pairs per datapath
  function automatic logic widthOk(input logic [1:0] p, input logic [7:0] f, input logic [7:0] w);
    logic ok;
    ok = 1'b0;
    if (p == PATH_STD)
      ok = (f == 8'h08 && w == 8'h08) || (f == 8'h0a && w == 8'h0a)
        || (f == 8'h10 && (w == 8'h08 || w == 8'h10))
        || (f == 8'h14 && (w == 8'h0a || w == 8'h14))
        || (f == 8'h20 && w == 8'h10) || (f == 8'h28 && w == 8'h14);
    else if (p == PATH_TENG)
      ok = (f == 8'h20 && w == 8'h20) || (f == 8'h28 && w == 8'h28)
        || (f == 8'h32 && w == 8'h28) || (f == 8'h40 && (w == 8'h20 || w == 8'h40))
        || (f == 8'h42 && w == 8'h28);
    else if (p == PATH_HS128)
      ok = (f == 8'h80);
    return ok;
  endfunction : widthOk

  function automatic logic [WORD_W-1:0] wordMask(input logic [7:0] bits);
    return (128'h1 << bits) - 128'h1;
  endfunction : wordMask
endpackage : llsfd_pkg

// ===== shared/llsfd_fifo_if.sv
// port bundle of one phase-compensation fifo
`timescale 1ns/1ps
interface llsfd_fifo_if;
  import llsfd_pkg::*;
  logic push;
  logic pop;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] rdata;
  logic full;
  logic empty;
  logic [3:0] count;
  modport store (input push, input pop, input wdata, output rdata, output full, output empty, output count);
  modport client (output push, output pop, output wdata, input rdata, input full, input empty, input count);
endinterface : llsfd_fifo_if

// ===== hdl/llsfd_phase_fifo.sv
// phase-compensation fifo between fabric and pcs word streams
`timescale 1ns/1ps
module llsfd_phase_fifo
  import llsfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  llsfd_fifo_if.store port
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
  } llsfd_fifo_s;
  llsfd_fifo_s q;
  llsfd_fifo_s d;

  assign port.count = q.wp - q.rp;
  assign port.full = (port.count == FIFO_FULL);
  assign port.empty = (port.count == 4'h0);
  assign port.rdata = q.mem[q.rp[2:0]];

  always_comb
  begin
    d = q;
    if (port.push && !port.full)
    begin
      d.mem[q.wp[2:0]] = port.wdata;
      d.wp = q.wp + 4'h1;
    end
    if (port.pop && !port.empty)
      d.rp = q.rp + 4'h1;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_fifo_bound;
    port.count <= FIFO_FULL;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth"); // R18
  property p_fifo_grow;
    (port.push && !port.full && !port.pop) |=> port.count == $past(port.count) + 4'h1;
  endproperty
  a_fifo_grow: assert property (p_fifo_grow) else $error("accepted word not counted"); // R18
endmodule : llsfd_phase_fifo

// ===== hdl/llsfd_tick_gen.sv
// parallel word tick: one pulse every div line bits
`timescale 1ns/1ps
module llsfd_tick_gen
  import llsfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic [7:0] div,
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
  } llsfd_tick_s;
  llsfd_tick_s q;
  llsfd_tick_s d;

  assign tick = en && (q.cnt == div - 8'h01);

  always_comb
  begin
    d = q;
    if (!en || tick)
      d.cnt = 8'h00;
    else
      d.cnt = q.cnt + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_tick_gap;
    (tick && div > 8'h01) |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("parallel ticks back to back"); // R8
endmodule : llsfd_tick_gen

// ===== hdl/llsfd_datapath.sv
// fabric-side datapath and clocking configuration of the transceiver phy
// Behaviour
// [R1] 32/40 bits: standard default, ten-gig optional
// [R2] duplex, receive-only or transmit-only operation
// [R3] lanes 1..32; high-speed path at most 4
// [R4] bonding: up to 6 channels, standard only; cross-bank bonding is granted with more than 6 lanes
// [R5] several transmit plls disable bonding
// [R6] cross-bank bonding: refclk equals rate over pma
// [R7] fabric widths listed; high-speed path only 128
// [R8] parallel clock is rate over fabric width
// [R9] standard path fabric to pcs-pma width map
// [R10] ten-gig path fabric to pcs-pma width map
// [R11] 50:40 ticks at /40, fabric returns core
// [R12] ten-gig 64:32 ticks at /32, fabric returns core
// [R13] tx core input clocks tx fifo write
// [R14] tx core input mandatory for 50:40, 64:32
// [R15] bonded uses one pll; else one each
// [R16] rx core input clocks rx fifo read
// [R17] fabric core clocks match phy rate
// [R18] fifos keep order, no loss or duplication; a word the full fifo cannot take is dropped and flagged
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module llsfd_datapath
  import llsfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [WORD_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  input wire logic txCoreTick,
  input wire logic rxCoreTick,
  output logic txClkOut,
  output logic rxClkOut,
  output logic [WORD_W-1:0] txPcsData,
  output logic txPcsValid,
  input wire logic [WORD_W-1:0] rxPcsData,
  input wire logic rxPcsValid,
  output logic [WORD_W-1:0] rxData,
  output logic rxValid
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic ack;
    logic [31:0] rdat;
    logic cfgOk;
    logic widthErr;
    logic laneErr;
    logic bondErr;
    logic coreErr;
    logic bondAct;
    logic [7:0] parDiv;
    logic [7:0] refDiv;
    logic [2:0] pllEff;
    logic txDrop;
    logic txStarve;
    logic rxDrop;
    logic txReady;
    logic txClk;
    logic rxClk;
    logic [WORD_W-1:0] txPcs;
    logic txPcsV;
    logic [WORD_W-1:0] rxWord;
    logic rxV;
  } llsfd_state_s;
  llsfd_state_s q;
  llsfd_state_s d;

  logic [1:0] cPath;
  logic [1:0] cMode;
  logic [5:0] cLanes;
  logic cBondEn;
  logic cBondX;
  logic [7:0] cFab;
  logic [7:0] cPma;
  logic cTxCore;
  logic cRxCore;
  logic [1:0] cPll;
  logic excRatio;
  logic widthBad;
  logic laneBad;
  logic coreBad;
  logic bondGrant;
  logic txEn;
  logic rxEn;
  logic txTick;
  logic rxTick;
  logic txFabTick;
  logic rxFabTick;
  logic txPushTry;
  logic [3:0] txCntNext;
  logic req;
  logic [31:0] statusWord;
  logic [31:0] clocksWord;

  llsfd_fifo_if txIf();
  llsfd_fifo_if rxIf();

  ////////////////////////////////////////////////////////////////
  // configuration fields
  assign cPath = q.ctrl[CTRL_PATH_LSB +: 2];
  assign cMode = q.ctrl[CTRL_MODE_LSB +: 2];
  assign cLanes = q.ctrl[CTRL_LANES_LSB +: 6];
  assign cBondEn = q.ctrl[CTRL_BOND_EN];
  assign cBondX = q.ctrl[CTRL_BOND_XBANK];
  assign cFab = fabBits(q.ctrl[CTRL_FAB_LSB +: 4]);
  assign cPma = pmaBits(q.ctrl[CTRL_PMA_LSB +: 3]);
  assign cTxCore = q.ctrl[CTRL_TXCORE];
  assign cRxCore = q.ctrl[CTRL_RXCORE];
  assign cPll = q.ctrl[CTRL_PLL_LSB +: 2];

  // ratios where the phy ticks at the pcs-pma width
  assign excRatio = (cFab == 8'h32 && cPma == 8'h28) // R11
    || (cPath == PATH_TENG && cFab == 8'h40 && cPma == 8'h20); // R12
  assign widthBad = !widthOk(cPath, cFab, cPma); // R1 R7 R9 R10
  assign laneBad = (cLanes == 6'h00) || (cLanes > MAX_LANES)
    || (cPath == PATH_HS128 && cLanes > HS_MAX_LANES); // R3
  assign coreBad = excRatio && ((cMode != MODE_RX && !cTxCore)
    || (cMode != MODE_TX && !cRxCore)); // R14
  // bank bonding limited to six channels, standard path, single pll
  assign bondGrant = cBondEn && cPath == PATH_STD && cPll == 2'h0
    && (cBondX || cLanes <= BOND_MAX_CH); // R4 R5

  assign txEn = q.cfgOk && cMode != MODE_RX; // R2
  assign rxEn = q.cfgOk && cMode != MODE_TX; // R2

  ////////////////////////////////////////////////////////////////
  // parallel word ticks of the pcs side
  llsfd_tick_gen txTickGen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .en(txEn),
    .div(q.parDiv),
    .tick(txTick)
  );
  llsfd_tick_gen rxTickGen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .en(rxEn),
    .div(q.parDiv),
    .tick(rxTick)
  );

  llsfd_phase_fifo txFifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .port(txIf.store)
  );
  llsfd_phase_fifo rxFifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .port(rxIf.store)
  );

  ////////////////////////////////////////////////////////////////
  // fifo steering
  assign txFabTick = cTxCore ? txCoreTick : txTick; // R13
  assign rxFabTick = cRxCore ? rxCoreTick : rxTick; // R16
  assign txPushTry = txEn && txValid && txFabTick;
  assign txIf.push = txPushTry && q.txReady; // R18
  assign txIf.wdata = txData & wordMask(cFab);
  assign txIf.pop = txEn && txTick && !txIf.empty; // R18
  assign txCntNext = txIf.count + {3'h0, txIf.push} - {3'h0, txIf.pop};
  assign rxIf.push = rxEn && rxPcsValid && !rxIf.full; // R18
  assign rxIf.wdata = rxPcsData;
  assign rxIf.pop = rxEn && rxFabTick && !rxIf.empty; // R16

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign statusWord = {23'h0, q.rxDrop, q.txStarve, q.txDrop, q.bondAct,
    q.coreErr, q.bondErr, q.laneErr, q.widthErr, q.cfgOk};
  assign clocksWord = {13'h0, q.pllEff, q.refDiv, q.parDiv};

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    // wishbone slave, one wait state
    d.ack = req;
    if (req && wb_we_i && wb_adr_i == ADDR_CTRL)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wb_sel_i[b])
          d.ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
      end
      d.ctrl = d.ctrl & CTRL_WMASK;
    end
    if (req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ADDR_CTRL: d.rdat = q.ctrl;
        ADDR_STATUS: d.rdat = statusWord;
        ADDR_CLOCKS: d.rdat = clocksWord;
        default: d.rdat = 32'h0;
      endcase
    end
    // configuration check
    d.widthErr = widthBad;
    d.laneErr = laneBad;
    d.coreErr = coreBad;
    d.cfgOk = !widthBad && !laneBad && !coreBad && cMode != 2'h3;
    d.bondAct = bondGrant;
    d.bondErr = cBondEn && !bondGrant;
    d.parDiv = excRatio ? cPma : cFab; // R8 R11 R12
    d.refDiv = (bondGrant && cBondX) ? cPma : 8'h00; // R6
    d.pllEff = bondGrant ? 3'h1 : {1'b0, cPll} + 3'h1; // R15
    // sticky flags, a new event beats a clear
    if (req && wb_we_i && wb_adr_i == ADDR_STATUS)
    begin
      d.txDrop = q.txDrop && !wb_dat_i[ST_TX_DROP];
      d.txStarve = q.txStarve && !wb_dat_i[ST_TX_STARVE];
      d.rxDrop = q.rxDrop && !wb_dat_i[ST_RX_DROP];
    end
    if (txPushTry && !q.txReady)
      d.txDrop = 1'b1;
    if (txEn && txTick && txIf.empty)
      d.txStarve = 1'b1;
    if (rxEn && rxPcsValid && rxIf.full)
      d.rxDrop = 1'b1;
    // datapath outputs
    d.txReady = txEn && (txCntNext < FIFO_FULL);
    d.txClk = txTick; // R8
    d.rxClk = rxTick; // R8
    d.txPcsV = txIf.pop;
    if (txIf.pop)
      d.txPcs = txIf.rdata;
    d.rxV = rxIf.pop;
    if (rxIf.pop)
      d.rxWord = rxIf.rdata & wordMask(cFab);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
    end
    else
      q <= d;
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign txReady = q.txReady;
  assign txClkOut = q.txClk;
  assign rxClkOut = q.rxClk;
  assign txPcsData = q.txPcs;
  assign txPcsValid = q.txPcsV;
  assign rxData = q.rxWord;
  assign rxValid = q.rxV;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_wb_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_wb_ack;
    req |=> s_wb_answer;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus answer not a single cycle ack");

  property p_std_32;
    (cPath == PATH_STD && cFab == 8'h20 && cPma == 8'h10) |=> !q.widthErr;
  endproperty
  a_std_32: assert property (p_std_32) else $error("standard 32:16 flagged illegal"); // R1

  sequence s_rx_only;
    cMode == MODE_RX ##1 cMode == MODE_RX;
  endsequence
  property p_rx_only;
    s_rx_only |=> !txPcsValid;
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("transmit word in receive-only mode"); // R2

  property p_lanes_hs;
    (cPath == PATH_HS128 && cLanes > HS_MAX_LANES) |=> q.laneErr && !q.cfgOk;
  endproperty
  a_lanes_hs: assert property (p_lanes_hs) else $error("high-speed lane limit missed"); // R3

  property p_bond_std;
    (cBondEn && cPath != PATH_STD) |=> !q.bondAct && q.bondErr;
  endproperty
  a_bond_std: assert property (p_bond_std) else $error("bonding outside standard path"); // R4

  property p_bond_pll;
    (cPll != 2'h0) |=> !q.bondAct && q.pllEff == $past({1'b0, cPll}) + 3'h1;
  endproperty
  a_bond_pll: assert property (p_bond_pll) else $error("bonding with several plls"); // R5

  property p_ref_div;
    bondGrant && cBondX |=> q.refDiv == $past(cPma);
  endproperty
  a_ref_div: assert property (p_ref_div) else $error("cross-bank refclk divisor wrong"); // R6

  property p_hs_width;
    (cPath == PATH_HS128 && cFab != 8'h80) |=> q.widthErr;
  endproperty
  a_hs_width: assert property (p_hs_width) else $error("high-speed path accepted non-128"); // R7

  property p_div_plain;
    !excRatio |=> q.parDiv == $past(cFab);
  endproperty
  a_div_plain: assert property (p_div_plain) else $error("parallel divisor not fabric width"); // R8

  property p_div_5040;
    (cFab == 8'h32 && cPma == 8'h28) |=> q.parDiv == 8'h28;
  endproperty
  a_div_5040: assert property (p_div_5040) else $error("50:40 divisor not 40"); // R11

  property p_div_6432;
    (cPath == PATH_TENG && cFab == 8'h40 && cPma == 8'h20) |=> q.parDiv == 8'h20;
  endproperty
  a_div_6432: assert property (p_div_6432) else $error("64:32 divisor not 32"); // R12

  property p_tx_core;
    (cTxCore && !txCoreTick) |-> !txIf.push;
  endproperty
  a_tx_core: assert property (p_tx_core) else $error("tx fifo written off core tick"); // R13

  property p_core_mand;
    (excRatio && cMode != MODE_RX && !cTxCore) |=> q.coreErr && !q.cfgOk;
  endproperty
  a_core_mand: assert property (p_core_mand) else $error("missing tx core clock accepted"); // R14

  property p_pll_bonded;
    q.bondAct |-> q.pllEff == 3'h1;
  endproperty
  a_pll_bonded: assert property (p_pll_bonded) else $error("bonded config with several plls"); // R15

  property p_rx_core;
    (cRxCore && !rxCoreTick) |-> !rxIf.pop;
  endproperty
  a_rx_core: assert property (p_rx_core) else $error("rx fifo read off core tick"); // R16

  property p_tx_drop;
    (txPushTry && !q.txReady) |=> q.txDrop;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("refused word not flagged"); // R18
endmodule : llsfd_datapath

// ===== testbench/llsfd_fabric_model.sv
// fabric-side partner: derived core clock ticks and tx word source
`timescale 1ns/1ps
module llsfd_fabric_model
  import llsfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic [7:0] coreDiv,
  input wire logic [7:0] nWords,
  input wire logic txReady,
  output logic txCoreTick,
  output logic rxCoreTick,
  output logic [WORD_W-1:0] txData,
  output logic txValid
);
  logic [7:0] divCnt;
  logic [7:0] sent;
  logic wrap;
  assign wrap = (divCnt == coreDiv - 8'h01);
  ////////////////////////////////////////////////////////////////////////////
  // one core tick per coreDiv cycles, both directions
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn || !en)
    begin
      divCnt <= 8'h00;
      txCoreTick <= 1'b0;
      rxCoreTick <= 1'b0;
      sent <= 8'h00;
      txValid <= 1'b0;
      txData <= '0;
    end
    else
    begin
      divCnt <= wrap ? 8'h00 : divCnt + 8'h01;
      txCoreTick <= wrap;
      rxCoreTick <= wrap;
      txValid <= (sent < nWords);
      if (txCoreTick && txValid && txReady)
      begin
        sent <= sent + 8'h01;
        txData <= {16{sent + 8'h01}};
      end
      else if (sent >= nWords)
        txData <= ~txData;
    end
  end
endmodule : llsfd_fabric_model

// ===== testbench/llsfd_datapath_tb.sv
// self-checking bench of the fabric datapath block
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t %s", $time, m); end end
module llsfd_datapath_tb
  import llsfd_pkg::*;
;
  typedef struct {logic [31:0] ctrl; logic [5:0] st; logic [7:0] div; logic [7:0] refd; int per;} llsfd_row_s;
  logic ref_clk = 1'b0, resetn = 1'b0;
  logic wbCyc = 0, wbStb = 0, wbWe = 0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO, rdv;
  logic wbAck, txValid, txReady, txCoreTick, rxCoreTick, txClkOut, rxClkOut, txPcsValid, rxValid;
  logic rxPcsValid = 1'b0, mEn = 1'b0;
  logic [7:0] mDiv = 8'h40, mWords = 8'h00;
  logic [WORD_W-1:0] txData, txPcsData, rxData;
  logic [WORD_W-1:0] rxPcsData = '0;
  int n_mismatch = 0, n_tests = 0, p, nT, nR, k;
  llsfd_row_s rows [23] = '{
    '{32'h0000_0010, 6'h01, 8'h08, 8'h00, 8}, '{32'h0000_2010, 6'h01, 8'h10, 8'h00, 16},
    '{32'h0003_5010, 6'h01, 8'h28, 8'h00, 40}, '{32'h0004_4011, 6'h01, 8'h20, 8'h00, 32},
    '{32'h0006_7011, 6'h01, 8'h40, 8'h00, 64}, '{32'h001c_7011, 6'h01, 8'h20, 8'h00, 32},
    '{32'h001d_6011, 6'h01, 8'h28, 8'h00, 40}, '{32'h0004_7011, 6'h10, 8'h00, 8'h00, 0},
    '{32'h0005_6011, 6'h10, 8'h00, 8'h00, 0}, '{32'h0004_4010, 6'h02, 8'h00, 8'h00, 0},
    '{32'h0000_7012, 6'h02, 8'h00, 8'h00, 0}, '{32'h0000_9042, 6'h01, 8'h80, 8'h00, 128},
    '{32'h0000_9052, 6'h04, 8'h00, 8'h00, 0}, '{32'h0000_0210, 6'h04, 8'h00, 8'h00, 0},
    '{32'h0000_0200, 6'h01, 8'h08, 8'h00, 8}, '{32'h0000_0460, 6'h21, 8'h08, 8'h00, 8},
    '{32'h0000_0470, 6'h09, 8'h08, 8'h00, 8}, '{32'h0006_7411, 6'h09, 8'h40, 8'h00, 64},
    '{32'h0020_0460, 6'h09, 8'h08, 8'h00, 8}, '{32'h0000_0c60, 6'h21, 8'h08, 8'h08, 8},
    '{32'h0000_0014, 6'h01, 8'h08, 8'h00, 0}, '{32'h0000_0018, 6'h01, 8'h08, 8'h00, 8},
    '{32'h0002_4010, 6'h01, 8'h20, 8'h00, 32}};
  always #2.5 ref_clk = ~ref_clk;
  llsfd_datapath i_llsfd_datapath (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .txData(txData), .txValid(txValid), .txReady(txReady), .txCoreTick(txCoreTick), .rxCoreTick(rxCoreTick),
    .txClkOut(txClkOut), .rxClkOut(rxClkOut), .txPcsData(txPcsData), .txPcsValid(txPcsValid),
    .rxPcsData(rxPcsData), .rxPcsValid(rxPcsValid), .rxData(rxData), .rxValid(rxValid));
  llsfd_fabric_model i_llsfd_fabric_model (.ref_clk(ref_clk), .resetn(resetn), .en(mEn), .coreDiv(mDiv),
    .nWords(mWords), .txReady(txReady), .txCoreTick(txCoreTick), .rxCoreTick(rxCoreTick), .txData(txData),
    .txValid(txValid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int j;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatI <= dat;
    for (j = 0; j < 50 && wbAck !== 1'b1; j++)
      @(posedge ref_clk);
    rdv = wbDatO;
    if (j == 50)
      `CHK(1'b0, 1'b1, "bus timeout")
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge ref_clk);
  endtask : wbXfer

  // interval between the 2nd and 3rd tx parallel clock pulse, 0 if silent
  task automatic getPeriod(output int per);
    int c;
    per = 0;
    for (int j = 0; j < 3; j++)
    begin
      for (c = 1; c <= 300 && txClkOut !== 1'b1; c++)
        @(posedge ref_clk);
      if (c > 300)
      begin
        per = 0;
        return;
      end
      per = c;
      @(posedge ref_clk);
    end
  endtask : getPeriod

  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    `CHK({txReady, wbAck, txPcsValid, rxValid, txClkOut}, 5'h00, "outputs in reset")
    resetn <= 1'b1;
    @(posedge ref_clk);
    wbXfer(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    `CHK(rdv, 32'h0000_0010, "ctrl reset value")
    wbXfer(1'b0, ADDR_STATUS, 4'hf, 32'h0);
    `CHK(rdv[5:0], 6'h01, "status reset value")
    wbXfer(1'b1, ADDR_CTRL, 4'hf, 32'hffff_ffff);
    wbXfer(1'b1, ADDR_CTRL, 4'h1, 32'hffff_ff10);
    wbXfer(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    `CHK(rdv, 32'h007f_ff10, "ctrl byte merge and reserved bits")
    wbXfer(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
    wbXfer(1'b0, 8'h0c, 4'hf, 32'h0);
    `CHK(rdv, 32'h0, "unmapped read")
    $display("register test done");
    foreach (rows[i])
    begin
      wbXfer(1'b1, ADDR_CTRL, 4'hf, rows[i].ctrl);
      wbXfer(1'b1, ADDR_CLOCKS, 4'hf, 32'hffff_ffff);
      wbXfer(1'b0, ADDR_STATUS, 4'hf, 32'h0);
      `CHK(rdv[5:0], rows[i].st, "status")
      wbXfer(1'b0, ADDR_CLOCKS, 4'hf, 32'h0);
      if (rows[i].div != 8'h00)
      begin
        `CHK(rdv[15:0], {rows[i].refd, rows[i].div}, "clocks")
        `CHK(rdv[18:16], rows[i].st[5] ? 3'h1 : {1'b0, rows[i].ctrl[22:21]} + 3'h1, "plls")
      end
      getPeriod(p);
      `CHK(p, rows[i].per, "tx parallel clock period")
    end
    $display("configuration table done");
    // ten-gig 64:32, both core inputs fed by the fabric at rate over 64
    wbXfer(1'b1, ADDR_CTRL, 4'hf, 32'h001c_7011);
    mDiv <= 8'h40;
    mWords <= 8'h05;
    mEn <= 1'b1;
    for (int j = 0; j < 3; j++)
    begin
      rxPcsData <= {16{8'ha0 + j[7:0]}};
      rxPcsValid <= 1'b1;
      @(posedge ref_clk);
    end
    rxPcsValid <= 1'b0;
    rxPcsData <= '1;
    nT = 0;
    nR = 0;
    for (k = 0; k < 3000 && (nT < 5 || nR < 3); k++)
    begin
      @(posedge ref_clk);
      if (txPcsValid === 1'b1)
      begin
        `CHK(txPcsData, {64'h0, {8{nT[7:0]}}}, "tx word order")
        nT++;
      end
      if (rxValid === 1'b1)
      begin
        `CHK(rxData, {64'h0, {8{8'ha0 + nR[7:0]}}}, "rx word order")
        nR++;
      end
    end
    `CHK(k < 3000, 1'b1, "stream timeout")
    wbXfer(1'b0, ADDR_STATUS, 4'hf, 32'h0);
    `CHK(rdv[8:6], 3'h2, "stream status flags")
    $display("stream test done");
    // fabric ticks faster than the pcs side: fifo fills and refuses
    mEn <= 1'b0;
    wbXfer(1'b1, ADDR_CTRL, 4'hf, 32'h000e_7011);
    mDiv <= 8'h04;
    mWords <= 8'h14;
    mEn <= 1'b1;
    for (k = 0; k < 500 && txReady !== 1'b0; k++)
      @(posedge ref_clk);
    `CHK(k > 20 && k < 500, 1'b1, "tx fifo refuses when full")
    // pcs side floods the rx fifo faster than it drains
    rxPcsValid <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rxPcsValid <= 1'b0;
    repeat (28) @(posedge ref_clk);
    wbXfer(1'b0, ADDR_STATUS, 4'hf, 32'h0);
    `CHK(rdv[6], 1'b1, "tx drop flag")
    `CHK(rdv[8], 1'b1, "rx drop flag")
    mEn <= 1'b0;
    repeat (700) @(posedge ref_clk);
    wbXfer(1'b1, ADDR_STATUS, 4'hf, 32'h0000_0040);
    wbXfer(1'b0, ADDR_STATUS, 4'hf, 32'h0);
    `CHK(rdv[6], 1'b0, "tx drop flag cleared")
    `CHK(txReady, 1'b1, "tx fifo drained")
    $display("overflow test done");
    resetn <= 1'b0;
    @(posedge ref_clk);
    `CHK({txReady, txPcsValid, txClkOut}, 3'h0, "outputs in second reset")
    resetn <= 1'b1;
    @(posedge ref_clk);
    wbXfer(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    `CHK(rdv, 32'h0000_0010, "ctrl after second reset")
    // both word clocks start together after reset in duplex
    for (k = 0; k < 20 && txClkOut !== 1'b1; k++)
      @(posedge ref_clk);
    `CHK({txClkOut, rxClkOut}, 2'h3, "rx parallel clock beside tx")
    $display("second reset test done");
    print_verdict();
  end
endmodule : llsfd_datapath_tb
